// [rtl/rtcc_control.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Update inhibit clear lets seconds advance.
// - Update inhibit untouched by reset or hardware.
// - Periodic enable gates interrupt, flag still sets.
// - Periodic enable cleared by reset only.
// - Alarm event per matching second, don't-care bytes.
// - Alarm enable gates alarm interrupt, flag still sets; reset clears.
// - Update-end enable cleared by reset, inhibit rise.
// - Square wave at tap when enabled, else low.
// - Data mode selects binary or BCD counting.
// - Hour format selects 24 or 12 hours.
// - Last April Sunday skips 2 AM hour.
// - Last October Sunday repeats 1 AM once.
// - No seasonal change without enable; enable kept.
// - Request flag is OR of gated flags.
// - Interrupt pin low while request flag set.
// - Reset clears all flags; status read clears all but one set that cycle.
// - Periodic flag sets on selected tap edge.
// - Alarm flag sets on time match.
// - Update-end flag sets after every update.
// - Status low nibble reads zero, ignores writes.
// - Rate select picks tap; zero disables.
module rtcc_control
  import rtcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic timeBaseTick,
  input wire logic [7:0] dayOfWeek,
  input wire logic [7:0] dateOfMonth,
  input wire logic [7:0] monthOfYear,
  output logic squareWaveOut,
  output logic irqNOut,
  output logic irqNOe
);

  typedef struct packed {
    logic updateInhibit;
    logic periodicIrqEnable;
    logic alarmIrqEnable;
    logic updateEndIrqEnable;
    logic squareWaveEnable;
    logic binaryDataMode;
    logic hour24Mode;
    logic daylightSavingEnable;
    logic [3:0] rateSelect;
    logic [7:0] alarmSec;
    logic [7:0] alarmMin;
    logic [7:0] alarmHr;
    logic periodicFlag;
    logic alarmFlag;
    logic updateEndFlag;
    logic [RTCC_DIV_WIDTH-1:0] divCount;
    logic tapPrev;
    logic updatePending;
    logic squareWave;
    logic [7:0] rdData;
  } rtcc_ctl_state_t;

  rtcc_ctl_state_t state_r;
  rtcc_ctl_state_t state_nxt;

  logic [7:0] seconds;
  logic [7:0] minutes;
  logic [7:0] hours;
  logic [RTCC_DIV_WIDTH-1:0] divAdvanced;
  logic [3:0] tapIndex;
  logic tapLevel;
  logic secondEdge;
  logic stepTime;
  logic alarmMatch;
  logic irqRequestFlag;
  logic statusRead;
  logic [7:0] controlB;
  logic [7:0] statusC;
  logic wrSec;
  logic wrMin;
  logic wrHr;

  function automatic logic alarmByteMatch(input logic [7:0] alarmByte, input logic [7:0] timeByte);
    return (alarmByte[7:6] == RTCC_ALARM_DONT_CARE) || (alarmByte == timeByte);
  endfunction : alarmByteMatch

  always_comb begin
    divAdvanced = state_r.divCount + {{(RTCC_DIV_WIDTH-1){1'b0}}, 1'b1};
    case (state_r.rateSelect)
      4'h1: tapIndex = RTCC_RATE_CODE1_TAP;
      4'h2: tapIndex = RTCC_RATE_CODE2_TAP;
      default: tapIndex = state_r.rateSelect - RTCC_RATE_TAP_OFFSET;
    endcase
    tapLevel = (state_r.rateSelect != RTCC_RATE_OFF) && state_r.divCount[tapIndex];
    secondEdge = timeBaseTick && state_r.divCount[RTCC_DIV_SECOND_BIT] && !divAdvanced[RTCC_DIV_SECOND_BIT];
    stepTime = secondEdge && !state_r.updateInhibit;
    alarmMatch = alarmByteMatch(state_r.alarmSec, seconds) &&
                 alarmByteMatch(state_r.alarmMin, minutes) &&
                 alarmByteMatch(state_r.alarmHr, hours);
    irqRequestFlag = (state_r.periodicFlag && state_r.periodicIrqEnable) ||
                     (state_r.alarmFlag && state_r.alarmIrqEnable) ||
                     (state_r.updateEndFlag && state_r.updateEndIrqEnable);
    statusRead = regRd && (regAddr == RTCC_OFF_INTERRUPT_FLAG_STATUS_C);
    wrSec = regWr && (regAddr == RTCC_OFF_SECONDS);
    wrMin = regWr && (regAddr == RTCC_OFF_MINUTES);
    wrHr = regWr && (regAddr == RTCC_OFF_HOURS);
    controlB = '0;
    controlB[RTCC_B_UPDATE_INHIBIT] = state_r.updateInhibit;
    controlB[RTCC_B_PERIODIC_IRQ_ENABLE] = state_r.periodicIrqEnable;
    controlB[RTCC_B_ALARM_IRQ_ENABLE] = state_r.alarmIrqEnable;
    controlB[RTCC_B_UPDATE_END_IRQ_ENABLE] = state_r.updateEndIrqEnable;
    controlB[RTCC_B_SQUARE_WAVE_ENABLE] = state_r.squareWaveEnable;
    controlB[RTCC_B_BINARY_DATA_MODE] = state_r.binaryDataMode;
    controlB[RTCC_B_HOUR24_MODE] = state_r.hour24Mode;
    controlB[RTCC_B_DAYLIGHT_SAVING_ENABLE] = state_r.daylightSavingEnable;
    statusC = '0;
    statusC[RTCC_C_IRQ_REQUEST_FLAG] = irqRequestFlag;
    statusC[RTCC_C_PERIODIC_FLAG] = state_r.periodicFlag;
    statusC[RTCC_C_ALARM_FLAG] = state_r.alarmFlag;
    statusC[RTCC_C_UPDATE_END_FLAG] = state_r.updateEndFlag;
  end

  rtcc_time_counter u_time_counter (
    .core_clk(core_clk),
    .nrst(nrst),
    .step(stepTime),
    .loadSec(wrSec),
    .loadMin(wrMin),
    .loadHr(wrHr),
    .loadData(regWrData),
    .binaryDataMode(state_r.binaryDataMode),
    .hour24Mode(state_r.hour24Mode),
    .daylightSavingEnable(state_r.daylightSavingEnable),
    .dayOfWeek(dayOfWeek),
    .dateOfMonth(dateOfMonth),
    .monthOfYear(monthOfYear),
    .seconds(seconds),
    .minutes(minutes),
    .hours(hours)
  );

  always_comb begin
    state_nxt = state_r;

    if (timeBaseTick) begin
      state_nxt.divCount = divAdvanced;
    end
    state_nxt.tapPrev = tapLevel;
    state_nxt.squareWave = state_r.squareWaveEnable && tapLevel;
    // The time bytes change one cycle after the step; alarm and update-end are judged then.
    state_nxt.updatePending = stepTime;

    // Read-to-clear first, so that a flag set in the same cycle survives.
    if (statusRead) begin
      state_nxt.periodicFlag = 1'b0;
      state_nxt.alarmFlag = 1'b0;
      state_nxt.updateEndFlag = 1'b0;
    end
    if (state_r.tapPrev && !tapLevel) begin
      state_nxt.periodicFlag = 1'b1;
    end
    if (state_r.updatePending && !state_r.updateInhibit) begin
      state_nxt.updateEndFlag = 1'b1;
      if (alarmMatch) begin
        state_nxt.alarmFlag = 1'b1;
      end
    end

    if (regWr) begin
      case (regAddr)
        RTCC_OFF_ALARM_SECONDS: state_nxt.alarmSec = regWrData;
        RTCC_OFF_ALARM_MINUTES: state_nxt.alarmMin = regWrData;
        RTCC_OFF_ALARM_HOURS: state_nxt.alarmHr = regWrData;
        RTCC_OFF_RATE_SELECT_A: state_nxt.rateSelect = regWrData[3:0];
        RTCC_OFF_CLOCK_CONTROL_B: begin
          state_nxt.updateInhibit = regWrData[RTCC_B_UPDATE_INHIBIT];
          state_nxt.periodicIrqEnable = regWrData[RTCC_B_PERIODIC_IRQ_ENABLE];
          state_nxt.alarmIrqEnable = regWrData[RTCC_B_ALARM_IRQ_ENABLE];
          state_nxt.updateEndIrqEnable = regWrData[RTCC_B_UPDATE_END_IRQ_ENABLE];
          state_nxt.squareWaveEnable = regWrData[RTCC_B_SQUARE_WAVE_ENABLE];
          state_nxt.binaryDataMode = regWrData[RTCC_B_BINARY_DATA_MODE];
          state_nxt.hour24Mode = regWrData[RTCC_B_HOUR24_MODE];
          state_nxt.daylightSavingEnable = regWrData[RTCC_B_DAYLIGHT_SAVING_ENABLE];
          if (regWrData[RTCC_B_UPDATE_INHIBIT] && !state_r.updateInhibit) begin
            state_nxt.updateEndIrqEnable = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    state_nxt.rdData = '0;
    if (regRd) begin
      case (regAddr)
        RTCC_OFF_SECONDS: state_nxt.rdData = seconds;
        RTCC_OFF_ALARM_SECONDS: state_nxt.rdData = state_r.alarmSec;
        RTCC_OFF_MINUTES: state_nxt.rdData = minutes;
        RTCC_OFF_ALARM_MINUTES: state_nxt.rdData = state_r.alarmMin;
        RTCC_OFF_HOURS: state_nxt.rdData = hours;
        RTCC_OFF_ALARM_HOURS: state_nxt.rdData = state_r.alarmHr;
        RTCC_OFF_RATE_SELECT_A: state_nxt.rdData = {4'h0, state_r.rateSelect};
        RTCC_OFF_CLOCK_CONTROL_B: state_nxt.rdData = controlB;
        RTCC_OFF_INTERRUPT_FLAG_STATUS_C: state_nxt.rdData = statusC;
        default: state_nxt.rdData = 8'h00;
      endcase
    end

    // Reset clears the interrupt and square wave enables, the flags, the divider and the pipeline registers; inhibit, mode and daylight saving bits hold.
    if (!nrst) begin
      state_nxt.periodicIrqEnable = 1'b0;
      state_nxt.alarmIrqEnable = 1'b0;
      state_nxt.updateEndIrqEnable = 1'b0;
      state_nxt.squareWaveEnable = 1'b0;
      state_nxt.periodicFlag = 1'b0;
      state_nxt.alarmFlag = 1'b0;
      state_nxt.updateEndFlag = 1'b0;
      state_nxt.divCount = '0;
      state_nxt.tapPrev = 1'b0;
      state_nxt.updatePending = 1'b0;
      state_nxt.squareWave = 1'b0;
      state_nxt.rdData = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    state_r <= state_nxt;
  end

  assign regRdData = state_r.rdData;
  assign squareWaveOut = state_r.squareWave;
  assign irqNOut = 1'b0;
  assign irqNOe = ~irqRequestFlag;

endmodule : rtcc_control

`default_nettype wire

// [rtl/rtcc_pkg.sv]
package rtcc_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] RTCC_OFF_SECONDS = 8'h00;
  localparam logic [7:0] RTCC_OFF_ALARM_SECONDS = 8'h01;
  localparam logic [7:0] RTCC_OFF_MINUTES = 8'h02;
  localparam logic [7:0] RTCC_OFF_ALARM_MINUTES = 8'h03;
  localparam logic [7:0] RTCC_OFF_HOURS = 8'h04;
  localparam logic [7:0] RTCC_OFF_ALARM_HOURS = 8'h05;
  localparam logic [7:0] RTCC_OFF_RATE_SELECT_A = 8'h0a;
  localparam logic [7:0] RTCC_OFF_CLOCK_CONTROL_B = 8'h0b;
  localparam logic [7:0] RTCC_OFF_INTERRUPT_FLAG_STATUS_C = 8'h0c;

  // Field positions in clock_control_b.
  localparam int RTCC_B_UPDATE_INHIBIT = 7;
  localparam int RTCC_B_PERIODIC_IRQ_ENABLE = 6;
  localparam int RTCC_B_ALARM_IRQ_ENABLE = 5;
  localparam int RTCC_B_UPDATE_END_IRQ_ENABLE = 4;
  localparam int RTCC_B_SQUARE_WAVE_ENABLE = 3;
  localparam int RTCC_B_BINARY_DATA_MODE = 2;
  localparam int RTCC_B_HOUR24_MODE = 1;
  localparam int RTCC_B_DAYLIGHT_SAVING_ENABLE = 0;

  // Field positions in interrupt_flag_status_c.
  localparam int RTCC_C_IRQ_REQUEST_FLAG = 7;
  localparam int RTCC_C_PERIODIC_FLAG = 6;
  localparam int RTCC_C_ALARM_FLAG = 5;
  localparam int RTCC_C_UPDATE_END_FLAG = 4;

  // Time base divider: 15 stages from the 32.768 kHz tick give one second.
  localparam int RTCC_DIV_WIDTH = 15;
  localparam int RTCC_DIV_SECOND_BIT = 14;
  localparam logic [3:0] RTCC_RATE_OFF = 4'h0;
  localparam logic [3:0] RTCC_RATE_TAP_OFFSET = 4'h2;
  localparam logic [3:0] RTCC_RATE_CODE1_TAP = 4'h6;
  localparam logic [3:0] RTCC_RATE_CODE2_TAP = 4'h7;

  // Alarm byte value whose two top bits set means "match anything".
  localparam logic [1:0] RTCC_ALARM_DONT_CARE = 2'b11;

  // Counting limits, binary and BCD.
  localparam logic [7:0] RTCC_MAX_SEC_BIN = 8'h3b;
  localparam logic [7:0] RTCC_MAX_SEC_BCD = 8'h59;
  localparam logic [7:0] RTCC_MAX_HR24_BIN = 8'h17;
  localparam logic [7:0] RTCC_MAX_HR24_BCD = 8'h23;
  localparam logic [6:0] RTCC_HR12_NOON_BIN = 7'h0c;
  localparam logic [6:0] RTCC_HR12_NOON_BCD = 7'h12;
  localparam logic [6:0] RTCC_HR12_ELEVEN_BIN = 7'h0b;
  localparam logic [6:0] RTCC_HR12_ELEVEN_BCD = 7'h11;
  localparam logic [7:0] RTCC_HR_ONE = 8'h01;
  localparam logic [7:0] RTCC_HR_THREE = 8'h03;
  localparam int RTCC_HR12_PM_BIT = 7;

  // Calendar figures used by the seasonal adjustment.
  localparam logic [7:0] RTCC_SUNDAY = 8'h01;
  localparam logic [7:0] RTCC_APRIL = 8'h04;
  localparam logic [7:0] RTCC_OCTOBER_BIN = 8'h0a;
  localparam logic [7:0] RTCC_OCTOBER_BCD = 8'h10;
  localparam logic [7:0] RTCC_LAST_WEEK_BIN = 8'h19;
  localparam logic [7:0] RTCC_LAST_WEEK_BCD = 8'h25;

endpackage : rtcc_pkg

// [rtl/rtcc_time_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module rtcc_time_counter
  import rtcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic step,
  input wire logic loadSec,
  input wire logic loadMin,
  input wire logic loadHr,
  input wire logic [7:0] loadData,
  input wire logic binaryDataMode,
  input wire logic hour24Mode,
  input wire logic daylightSavingEnable,
  input wire logic [7:0] dayOfWeek,
  input wire logic [7:0] dateOfMonth,
  input wire logic [7:0] monthOfYear,
  output logic [7:0] seconds,
  output logic [7:0] minutes,
  output logic [7:0] hours
);

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic octoberDone;
  } rtcc_time_state_t;

  rtcc_time_state_t state_r;
  rtcc_time_state_t state_nxt;

  function automatic logic [7:0] incCount(input logic [7:0] v, input logic bin);
    if (bin) begin
      return v + 8'h01;
    end
    return (v[3:0] == 4'h9) ? v + 8'h07 : v + 8'h01;
  endfunction : incCount

  logic [7:0] maxSec;
  logic [7:0] maxHr24;
  logic [6:0] noon;
  logic [6:0] eleven;
  logic lastSunday;
  logic aprilDay;
  logic octoberDay;
  logic atOneFiftyNine;
  logic [7:0] hr12Inc;

  always_comb begin
    maxSec = binaryDataMode ? RTCC_MAX_SEC_BIN : RTCC_MAX_SEC_BCD;
    maxHr24 = binaryDataMode ? RTCC_MAX_HR24_BIN : RTCC_MAX_HR24_BCD;
    noon = binaryDataMode ? RTCC_HR12_NOON_BIN : RTCC_HR12_NOON_BCD;
    eleven = binaryDataMode ? RTCC_HR12_ELEVEN_BIN : RTCC_HR12_ELEVEN_BCD;
    lastSunday = (dayOfWeek == RTCC_SUNDAY) &&
                 (dateOfMonth >= (binaryDataMode ? RTCC_LAST_WEEK_BIN : RTCC_LAST_WEEK_BCD));
    aprilDay = lastSunday && (monthOfYear == RTCC_APRIL);
    octoberDay = lastSunday && (monthOfYear == (binaryDataMode ? RTCC_OCTOBER_BIN : RTCC_OCTOBER_BCD));
    atOneFiftyNine = (state_r.sec == maxSec) && (state_r.min == maxSec) && (state_r.hr == RTCC_HR_ONE);
    hr12Inc = incCount({1'b0, state_r.hr[6:0]}, binaryDataMode);
  end

  always_comb begin
    state_nxt = state_r;
    if (!octoberDay) begin
      state_nxt.octoberDone = 1'b0;
    end
    if (step) begin
      if (daylightSavingEnable && aprilDay && atOneFiftyNine) begin
        state_nxt.sec = 8'h00;
        state_nxt.min = 8'h00;
        state_nxt.hr = RTCC_HR_THREE;
      end else if (daylightSavingEnable && octoberDay && atOneFiftyNine && !state_r.octoberDone) begin
        state_nxt.sec = 8'h00;
        state_nxt.min = 8'h00;
        state_nxt.hr = RTCC_HR_ONE;
        state_nxt.octoberDone = 1'b1;
      end else if (state_r.sec != maxSec) begin
        state_nxt.sec = incCount(state_r.sec, binaryDataMode);
      end else begin
        state_nxt.sec = 8'h00;
        if (state_r.min != maxSec) begin
          state_nxt.min = incCount(state_r.min, binaryDataMode);
        end else begin
          state_nxt.min = 8'h00;
          if (hour24Mode) begin
            state_nxt.hr = (state_r.hr == maxHr24) ? 8'h00 : incCount(state_r.hr, binaryDataMode);
          end else if (state_r.hr[6:0] == noon) begin
            state_nxt.hr = {state_r.hr[RTCC_HR12_PM_BIT], 7'h01};
          end else if (state_r.hr[6:0] == eleven) begin
            state_nxt.hr = {~state_r.hr[RTCC_HR12_PM_BIT], noon};
          end else begin
            state_nxt.hr = {state_r.hr[RTCC_HR12_PM_BIT], hr12Inc[6:0]};
          end
        end
      end
    end
    // A software load of a time byte takes priority over a coincident step.
    if (loadSec) begin
      state_nxt.sec = loadData;
    end
    if (loadMin) begin
      state_nxt.min = loadData;
    end
    if (loadHr) begin
      state_nxt.hr = loadData;
    end
    if (!nrst) begin
      state_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    state_r <= state_nxt;
  end

  assign seconds = state_r.sec;
  assign minutes = state_r.min;
  assign hours = state_r.hr;

endmodule : rtcc_time_counter

`default_nettype wire

// [tb/rtcc_control_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module rtcc_control_sva
  import rtcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic timeBaseTick,
  input wire logic [7:0] dayOfWeek,
  input wire logic [7:0] dateOfMonth,
  input wire logic [7:0] monthOfYear,
  input wire logic squareWaveOut,
  input wire logic irqNOut,
  input wire logic irqNOe
);
  logic [7:0] ctrlShadow_r;
  logic shadowValid_r;
  logic isCtrlWr;
  logic [7:0] ctrlNext;
  assign isCtrlWr = regWr && (regAddr == RTCC_OFF_CLOCK_CONTROL_B);
  // A write that raises the update inhibit also drops the update-end enable.
  always_comb begin
    ctrlNext = regWrData;
    if (regWrData[7] && !ctrlShadow_r[7]) begin
      ctrlNext[4] = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrlShadow_r[6:3] <= 4'h0;
      shadowValid_r <= 1'b0;
    end else if (isCtrlWr) begin
      ctrlShadow_r <= ctrlNext;
      shadowValid_r <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_quiet; !timeBaseTick [*4]; endsequence
  sequence s_status_rd; regRd && (regAddr == RTCC_OFF_INTERRUPT_FLAG_STATUS_C); endsequence
  sequence s_ctrl_rd; regRd && (regAddr == RTCC_OFF_CLOCK_CONTROL_B); endsequence
  property p_rd_idle; !regRd |=> (regRdData == 8'h00); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
  property p_status_low; s_status_rd |=> (regRdData[3:0] == 4'h0); endproperty
  a_status_low: assert property (p_status_low) else $error("status low nibble not zero");
  property p_irq_request_flag_bit; s_status_rd |=> (regRdData[7] == !$past(irqNOe)); endproperty
  a_irq_request_flag_bit: assert property (p_irq_request_flag_bit) else $error("request flag differs from pin");
  property p_status_clear; (s_quiet ##0 s_status_rd) |=> irqNOe; endproperty
  a_status_clear: assert property (p_status_clear) else $error("flags not cleared by status read");
  property p_ctrl_readback; (s_ctrl_rd ##0 shadowValid_r) |=> (regRdData == $past(ctrlShadow_r)); endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");
  property p_uie_clear;
    (isCtrlWr && regWrData[7] && !ctrlShadow_r[7] && shadowValid_r) ##[1:2] s_ctrl_rd |=> !regRdData[4];
  endproperty
  a_uie_clear: assert property (p_uie_clear) else $error("update-end enable kept");
  property p_sqw_off; (!ctrlShadow_r[3] && !$past(ctrlShadow_r[3])) |-> !squareWaveOut; endproperty
  a_sqw_off: assert property (p_sqw_off) else $error("square wave active while disabled");
  property p_irq_gate; (ctrlShadow_r[6:4] == 3'b000) |-> irqNOe; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("pin asserted with enables off");
  property p_pin_level; irqNOut == 1'b0; endproperty
  a_pin_level: assert property (p_pin_level) else $error("open-drain level not low");
endmodule : rtcc_control_sva
`default_nettype wire

// [tb/rtcc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rtcc_host_model (
  input wire logic core_clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Released lines show inverted values so stale data is never mistaken for valid.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    regAddr <= addr;
    regWrData <= data;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    regAddr <= ~addr;
    regWrData <= ~data;
  endtask : wr
  task automatic rd(input logic [7:0] addr);
    @(posedge core_clk);
    regAddr <= addr;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    regAddr <= ~addr;
  endtask : rd
endmodule : rtcc_host_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
  import rtcc_pkg::*;
;
  localparam logic [7:0] adrA = RTCC_OFF_RATE_SELECT_A;
  localparam logic [7:0] adrB = RTCC_OFF_CLOCK_CONTROL_B;
  localparam logic [7:0] adrC = RTCC_OFF_INTERRUPT_FLAG_STATUS_C;
  logic core_clk = 1'b0;
  logic nrst, regWr, regRd, timeBaseTick, squareWaveOut, irqNOut, irqNOe;
  logic [7:0] regAddr, regWrData, regRdData, dayOfWeek, dateOfMonth, monthOfYear;
  logic [7:0] expQ[$];
  logic rdSeen_r = 1'b0;
  int failCount = 0;
  int samplesChecked = 0;
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  rtcc_control u_rtcc_control (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .timeBaseTick(timeBaseTick), .dayOfWeek(dayOfWeek),
    .dateOfMonth(dateOfMonth), .monthOfYear(monthOfYear), .squareWaveOut(squareWaveOut), .irqNOut(irqNOut),
    .irqNOe(irqNOe));
  rtcc_host_model u_rtcc_host_model (.core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : closeOut
  // Read data belongs to the read strobe seen one edge earlier.
  always @(posedge core_clk) begin
    rdSeen_r <= regRd;
    if (rdSeen_r && expQ.size() > 0) begin
      check("read data", regRdData, expQ.pop_front());
    end
  end
  task automatic rdExp(input logic [7:0] addr, input logic [7:0] exp);
    expQ.push_back(exp);
    u_rtcc_host_model.rd(addr);
  endtask : rdExp
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    u_rtcc_host_model.wr(addr, data);
  endtask : wr
  task automatic doReset();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
  endtask : doReset
  task automatic runTicks(input int n);
    @(posedge core_clk);
    timeBaseTick <= 1'b1;
    repeat (n) @(posedge core_clk);
    timeBaseTick <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
  endtask : runTicks
  task automatic countSquare(output int hi);
    hi = 0;
    repeat (16) begin
      @(posedge core_clk);
      hi += int'(squareWaveOut === 1'b1);
    end
  endtask : countSquare
  initial begin
    repeat (100000) @(posedge core_clk);
    failCount++;
    closeOut();
  end
  initial begin
    logic [7:0] rnd;
    int hi;
    nrst = 1'b0;
    timeBaseTick = 1'b0;
    dayOfWeek = RTCC_SUNDAY;
    dateOfMonth = RTCC_LAST_WEEK_BCD;
    monthOfYear = RTCC_APRIL;
    void'($urandom(78578));
    doReset();
    rnd = 8'($urandom());
    wr(adrB, 8'h00);
    wr(adrB, rnd);
    rdExp(adrB, rnd[7] ? (rnd & 8'hef) : rnd);
    doReset();
    rdExp(adrB, rnd & 8'h87);
    wr(adrA, 8'h00);
    wr(adrC, 8'hff);
    rdExp(adrC, 8'h00);
    rdExp(8'h3f, 8'h00);
    wr(adrB, 8'h12);
    wr(adrB, 8'h92);
    rdExp(adrB, 8'h82);
    wr(adrB, 8'h02);
    wr(adrA, 8'h03);
    runTicks(16);
    check("irq pin idle", {7'h00, irqNOe}, 8'h01);
    rdExp(adrC, 8'h40);
    rdExp(adrC, 8'h00);
    wr(adrB, 8'h42);
    runTicks(16);
    check("irq pin active", {7'h00, irqNOe}, 8'h00);
    rdExp(adrC, 8'hc0);
    wr(adrA, 8'h00);
    runTicks(16);
    rdExp(adrC, 8'h00);
    wr(adrA, 8'h03);
    wr(adrB, 8'h0a);
    @(posedge core_clk);
    timeBaseTick <= 1'b1;
    countSquare(hi);
    check("square wave duty", {7'h00, hi >= 7 && hi <= 9}, 8'h01);
    wr(adrB, 8'h02);
    // The register still holds one sample taken while the enable was set.
    @(posedge core_clk);
    countSquare(hi);
    check("square wave off", 8'(hi), 8'h00);
    timeBaseTick <= 1'b0;
    doReset();
    wr(adrB, 8'h13);
    wr(adrA, 8'h00);
    wr(RTCC_OFF_SECONDS, 8'h59);
    wr(RTCC_OFF_MINUTES, 8'h59);
    wr(RTCC_OFF_HOURS, RTCC_HR_ONE);
    wr(RTCC_OFF_ALARM_SECONDS, 8'hc0);
    wr(RTCC_OFF_ALARM_MINUTES, 8'hc0);
    wr(RTCC_OFF_ALARM_HOURS, 8'hc0);
    runTicks(32800);
    rdExp(RTCC_OFF_HOURS, RTCC_HR_THREE);
    rdExp(RTCC_OFF_MINUTES, 8'h00);
    rdExp(RTCC_OFF_SECONDS, 8'h00);
    rdExp(adrC, 8'hb0);
    wr(adrB, 8'h93);
    runTicks(32800);
    rdExp(RTCC_OFF_SECONDS, 8'h00);
    rdExp(adrC, 8'h00);
    monthOfYear <= RTCC_OCTOBER_BIN;
    dateOfMonth <= RTCC_LAST_WEEK_BIN;
    wr(adrB, 8'h85);
    wr(RTCC_OFF_SECONDS, RTCC_MAX_SEC_BIN);
    wr(RTCC_OFF_MINUTES, RTCC_MAX_SEC_BIN);
    wr(RTCC_OFF_HOURS, RTCC_HR_ONE);
    wr(adrB, 8'h15);
    runTicks(32710);
    rdExp(RTCC_OFF_HOURS, RTCC_HR_ONE);
    rdExp(RTCC_OFF_MINUTES, 8'h00);
    rdExp(RTCC_OFF_SECONDS, 8'h00);
    rdExp(adrC, 8'hb0);
    repeat (3) @(posedge core_clk);
    closeOut();
  end
endmodule : tb
bind rtcc_control rtcc_control_sva u_rtcc_control_sva (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .timeBaseTick(timeBaseTick),
  .dayOfWeek(dayOfWeek), .dateOfMonth(dateOfMonth), .monthOfYear(monthOfYear),
  .squareWaveOut(squareWaveOut), .irqNOut(irqNOut), .irqNOe(irqNOe));
`default_nettype wire
